// File: hw/tlbiu_pkg.sv
// Constants, types and register map of the TLB invalidate unit
package tlbiu_pkg;
  localparam int unsigned ENTRIES = 16;
  localparam int unsigned IDXW = 4;
  localparam int unsigned ARRAYS = 4;
  localparam int unsigned ARRW = 2;
  localparam int unsigned REMOTES = 3;
  localparam int unsigned EAW = 64;
  localparam int unsigned EPNW = 52;
  localparam int unsigned LPIDW = 8;
  localparam int unsigned PIDW = 14;
  localparam int unsigned SIZEW = 4;
  localparam int unsigned ADDRW = 8;
  // Little-endian positions of big-endian EA bits 0-51, 59-60, 61
  localparam int unsigned EA_EPN_LSB = 12;
  localparam int unsigned EA_SEL_LSB = 3;
  localparam int unsigned EA_ALL_BIT = 2;
  localparam logic [1:0] TT_LPID = 2'h0;
  localparam logic [1:0] TT_PID = 2'h1;
  localparam logic [1:0] TT_BAD = 2'h2;
  localparam logic [1:0] TT_VA = 2'h3;
  localparam logic [IDXW-1:0] LAST_IDX = 4'hf;
  // Register byte offsets and fields
  localparam logic [ADDRW-1:0] REG_CTXA = 8'h00;
  localparam logic [ADDRW-1:0] REG_CTXB = 8'h04;
  localparam logic [ADDRW-1:0] REG_PCTL = 8'h08;
  localparam logic [ADDRW-1:0] REG_MCFG = 8'h0c;
  localparam logic [ADDRW-1:0] REG_STAT = 8'h10;
  localparam int unsigned CTXA_GS_BIT = 8;
  localparam int unsigned CTXB_AS_BIT = 16;
  localparam int unsigned PCTL_GUEST_TLB_MGMT_DISABLE_BIT = 0;
  localparam int unsigned PCTL_STRICT_BIT = 1;
  localparam int unsigned PCTL_HV_BIT = 2;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_PEND_BIT = 1;
  localparam int unsigned STAT_FLT_LSB = 4;
  localparam logic [31:0] PCTL_RST = 32'h0000_0004;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PRIV_USER = 2'h0, PRIV_GUEST = 2'h1, PRIV_HYP = 2'h2
  } tlbiu_priv_type;
  typedef enum logic [1:0] {
    FLT_NONE = 2'h0, FLT_FORM = 2'h1, FLT_PRIV = 2'h2, FLT_ILL = 2'h3
  } tlbiu_fault_type;
  typedef struct packed {
    logic valid;
    logic invalidate_protect;
    logic [LPIDW-1:0] lpid;
    logic [PIDW-1:0] pid;
    logic addr_space;
    logic guest_state;
    logic [SIZEW-1:0] size;
    logic [EPNW-1:0] effective_page_number;
  } tlbiu_entry_type;
  typedef struct packed {
    logic bcast;
    logic [1:0] ttype;
    logic v1;
    logic hv;
    logic all;
    logic [ARRW-1:0] sel;
    logic [LPIDW-1:0] lpid;
    logic [PIDW-1:0] pid;
    logic addr_space;
    logic guest_state;
    logic [EPNW-1:0] effective_page_number;
  } tlbiu_search_type;
  typedef struct packed {
    logic bcast;
    logic [1:0] ttype;
    logic [4:0] base_num;
    logic [EAW-1:0] base_val;
    logic [EAW-1:0] index_val;
    tlbiu_priv_type priv;
  } tlbiu_op_type;
endpackage

// File: hw/tlbiu_ea_gen.sv
// Effective address adder for the invalidate operations
`timescale 1ns/1ps
module tlbiu_ea_gen
  import tlbiu_pkg::*;
(
  input wire logic [4:0] base_num,
  input wire logic [EAW-1:0] base_val,
  input wire logic [EAW-1:0] index_val,
  output logic [EAW-1:0] ea,
  output logic base_used
);
  logic [EAW-1:0] base_term;

  // Register number zero contributes zero
  always_comb begin
    base_used = (base_num != 5'h00);
    base_term = base_used ? base_val : '0;
    ea = base_term + index_val;
  end
endmodule

// File: hw/tlbiu_match.sv
// Per-entry match logic for local and broadcast invalidates
`timescale 1ns/1ps
module tlbiu_match
  import tlbiu_pkg::*;
(
  input tlbiu_entry_type ent,
  input tlbiu_search_type srch,
  input wire logic [ARRW-1:0] arr,
  output logic kill
);
  logic [EPNW-1:0] mask;
  logic [5:0] shift;
  logic va_hit;
  logic lpid_eq;
  logic pid_eq;
  logic as_eq;
  logic gs_eq;
  logic part_ok;
  logic hit;

  always_comb begin
    shift = (ent.size == 4'h0) ? 6'h00 : {1'b0, ent.size - 4'h1, 1'b0};
    mask = ~((52'h1 << shift) - 52'h1);
    va_hit = ((srch.effective_page_number & mask) == (ent.effective_page_number & mask));
    lpid_eq = (ent.lpid == srch.lpid);
    pid_eq = (ent.pid == srch.pid);
    as_eq = (ent.addr_space == srch.addr_space);
    gs_eq = (ent.guest_state == srch.guest_state);
    part_ok = srch.hv ? (lpid_eq & gs_eq) : 1'b1;
    hit = 1'b0;
    if (srch.bcast) begin
      if (!srch.v1 || arr == srch.sel) begin
        hit = srch.all | (va_hit & pid_eq & as_eq & part_ok);
      end
    end else begin
      case (srch.ttype)
        TT_LPID: hit = lpid_eq;
        TT_PID: hit = lpid_eq & pid_eq;
        TT_VA: hit = lpid_eq & pid_eq & va_hit & as_eq & gs_eq;
        default: hit = 1'b0;
      endcase
    end
    kill = ent.valid & ~ent.invalidate_protect & hit;
  end
endmodule

// File: hw/tlbiu_top.sv
// TLB invalidate unit: local and broadcast invalidate engine
//
// Function
// - Local invalidate never clears entries marked invalidate-protect.
// - Type 0 clears unprotected entries whose partition matches.
// - Type 1 also requires process identifier match.
// - Type 3 matches partition, process, space, guest state, masked page.
// - Type 2 is an invalid form.
// - Address is base plus index; base register zero gives zero.
// - Local invalidate touches only this processor's arrays.
// - Extra invalidation allowed, but never of protected entries.
// - Effects need only be visible after context synchronization.
// - Local needs guest supervisor; hypervisor when guest management disabled.
// - Nonzero base register may raise illegal instruction.
// - Broadcast invalidate reaches every processor, including this one.
// - Broadcast matches masked page, process identifier and space.
// - With hypervisor support, partition and guest state must match.
// - Version one: address bits 59-60 select one of four arrays.
// - Version one: bit 61 set clears all unprotected in selected array.
// - Version one: bit 61 clear clears only matching selected entries.
// - Nonzero version searches all arrays and disables invalidate-all.
// - Broadcasts and syncs are ordered as their own set.
// - Broadcast needs hypervisor privilege, else privilege fault.
`timescale 1ns/1ps
module tlbiu_top
  import tlbiu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDRW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDRW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_valid,
  output logic op_ready,
  input tlbiu_op_type op,
  output logic op_done,
  output tlbiu_fault_type op_fault,
  output logic bcast_valid,
  input wire logic bcast_ready,
  output tlbiu_search_type bcast_out,
  input wire logic [REMOTES-1:0] remote_ack,
  output logic bcast_pending,
  input wire logic snoop_valid,
  output logic snoop_ready,
  input tlbiu_search_type snoop_in,
  output logic snoop_ack,
  input wire logic fill_valid,
  input wire logic [ARRW-1:0] fill_array,
  input wire logic [IDXW-1:0] fill_index,
  input tlbiu_entry_type fill_entry,
  input wire logic [ARRW-1:0] rd_array,
  input wire logic [IDXW-1:0] rd_index,
  output tlbiu_entry_type rd_entry
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SCAN = 5'h02,
    ST_BCAST = 5'h04,
    ST_WAIT = 5'h08,
    ST_DONE = 5'h10
  } tlbiu_state_type;

  tlbiu_state_type state_q;
  tlbiu_state_type state_d;
  tlbiu_entry_type tlb_q [ARRAYS][ENTRIES];
  tlbiu_search_type search_q;
  tlbiu_search_type search_d;
  tlbiu_fault_type fault_q;
  tlbiu_fault_type fault_d;
  logic [IDXW-1:0] scan_idx_q;
  logic snoop_job_q;
  logic [REMOTES-1:0] ack_seen_q;
  logic [ARRAYS-1:0] kill;
  logic [EAW-1:0] ea;
  logic base_used;
  logic op_take;
  logic snoop_take;
  logic scan_on;
  logic [31:0] ctxa_q;
  logic [31:0] ctxb_q;
  logic [31:0] pctl_q;
  logic [31:0] mcfg_q;
  logic [ADDRW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic wr_fire;

  tlbiu_ea_gen u_ea (
    .base_num(op.base_num),
    .base_val(op.base_val),
    .index_val(op.index_val),
    .ea(ea),
    .base_used(base_used)
  );

  // Parallel match on one index across all arrays
  genvar a;
  generate
    for (a = 0; a < ARRAYS; a++) begin : g_arr
      tlbiu_match u_match (
        .ent(tlb_q[a][scan_idx_q]),
        .srch(search_q),
        .arr(ARRW'(a)),
        .kill(kill[a])
      );
      chk_kill_protect: assert property (@(posedge aclk) disable iff (!aresetn)
        kill[a] |-> !tlb_q[a][scan_idx_q].invalidate_protect)
        else $error("protected entry selected for invalidation");
      chk_v1_inval_all: assert property (@(posedge aclk) disable iff (!aresetn)
        (scan_on && search_q.bcast && search_q.v1 && search_q.all &&
         search_q.sel == ARRW'(a) && tlb_q[a][scan_idx_q].valid &&
         !tlb_q[a][scan_idx_q].invalidate_protect) |-> kill[a])
        else $error("invalidate-all missed an unprotected entry");
    end
  endgenerate

  assign scan_on = (state_q == ST_SCAN);
  assign op_ready = (state_q == ST_IDLE) && !snoop_valid;
  assign snoop_ready = (state_q == ST_IDLE);
  assign op_take = op_valid && op_ready;
  assign snoop_take = snoop_valid && snoop_ready;
  assign op_done = (state_q == ST_DONE) && !snoop_job_q;
  assign snoop_ack = (state_q == ST_DONE) && snoop_job_q;
  assign op_fault = fault_q;
  assign bcast_valid = (state_q == ST_BCAST);
  assign bcast_out = search_q;
  assign bcast_pending = search_q.bcast && !snoop_job_q &&
                         (state_q != ST_IDLE);

  // Request check and search build
  always_comb begin
    fault_d = FLT_NONE;
    search_d = search_q;
    search_d.bcast = op.bcast;
    search_d.ttype = op.ttype;
    search_d.v1 = (mcfg_q[1:0] == 2'h0);
    search_d.hv = pctl_q[PCTL_HV_BIT];
    search_d.all = search_d.v1 & ea[EA_ALL_BIT];
    search_d.sel = ea[EA_SEL_LSB +: ARRW];
    search_d.lpid = ctxa_q[LPIDW-1:0];
    search_d.guest_state = ctxa_q[CTXA_GS_BIT];
    search_d.pid = ctxb_q[PIDW-1:0];
    search_d.addr_space = ctxb_q[CTXB_AS_BIT];
    search_d.effective_page_number = ea[EAW-1:EA_EPN_LSB];
    if (op.bcast) begin
      if (op.priv != PRIV_HYP) begin
        fault_d = FLT_PRIV;
      end
    end else if (op.priv == PRIV_USER ||
                 (pctl_q[PCTL_GUEST_TLB_MGMT_DISABLE_BIT] && op.priv != PRIV_HYP)) begin
      fault_d = FLT_PRIV;
    end else if (op.ttype == TT_BAD) begin
      fault_d = FLT_FORM;
    end else if (pctl_q[PCTL_STRICT_BIT] && base_used) begin
      fault_d = FLT_ILL;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (snoop_take) begin
          state_d = ST_SCAN;
        end else if (op_take) begin
          state_d = (fault_d == FLT_NONE) ? ST_SCAN : ST_DONE;
        end
      end
      ST_SCAN: begin
        if (scan_idx_q == LAST_IDX) begin
          // Local jobs stop here; only own broadcasts go out
          state_d = (search_q.bcast && !snoop_job_q) ? ST_BCAST
                                                     : ST_DONE;
        end
      end
      ST_BCAST: begin
        if (bcast_ready) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (&(ack_seen_q | remote_ack)) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Job capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      search_q <= '0;
      fault_q <= FLT_NONE;
      snoop_job_q <= 1'b0;
    end else if (snoop_take) begin
      search_q <= snoop_in;
      fault_q <= FLT_NONE;
      snoop_job_q <= 1'b1;
    end else if (op_take) begin
      search_q <= search_d;
      fault_q <= fault_d;
      snoop_job_q <= 1'b0;
    end
  end

  // Scan index, one entry per array per cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_idx_q <= '0;
    end else if (scan_on) begin
      scan_idx_q <= scan_idx_q + 4'h1;
    end else begin
      scan_idx_q <= '0;
    end
  end

  // Remote acknowledge collection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_seen_q <= '0;
    end else if (state_q == ST_IDLE) begin
      ack_seen_q <= '0;
    end else if (state_q == ST_BCAST || state_q == ST_WAIT) begin
      ack_seen_q <= ack_seen_q | remote_ack;
    end
  end

  // Entry storage: fill writes win over a same-cycle invalidate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ARRAYS; i++) begin
        for (int j = 0; j < ENTRIES; j++) begin
          tlb_q[i][j] <= '0;
        end
      end
    end else begin
      for (int i = 0; i < ARRAYS; i++) begin
        if (scan_on && kill[i]) begin
          tlb_q[i][scan_idx_q].valid <= 1'b0;
        end
      end
      if (fill_valid) begin
        tlb_q[fill_array][fill_index] <= fill_entry;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_entry <= '0;
    end else begin
      rd_entry <= tlb_q[rd_array][rd_index];
    end
  end

  // Register bus: write side
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q;
  assign wr_hit = (awaddr_q == REG_CTXA) || (awaddr_q == REG_CTXB) ||
                  (awaddr_q == REG_PCTL) || (awaddr_q == REG_MCFG);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctxa_q <= ZERO_RST;
      ctxb_q <= ZERO_RST;
      pctl_q <= PCTL_RST;
      mcfg_q <= ZERO_RST;
    end else if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) begin
          case (awaddr_q)
            REG_CTXA: ctxa_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            REG_CTXB: ctxb_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            REG_PCTL: pctl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            REG_MCFG: mcfg_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            default: ;
          endcase
        end
      end
    end
  end

  // Register bus: read side
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      REG_CTXA: rd_word = ctxa_q;
      REG_CTXB: rd_word = ctxb_q;
      REG_PCTL: rd_word = pctl_q;
      REG_MCFG: rd_word = mcfg_q;
      REG_STAT: begin
        rd_word[STAT_BUSY_BIT] = (state_q != ST_IDLE);
        rd_word[STAT_PEND_BIT] = bcast_pending;
        rd_word[STAT_FLT_LSB +: 2] = fault_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  chk_form_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_take && !op.bcast && op.ttype == TT_BAD && op.priv == PRIV_HYP)
    |=> (op_done && op_fault == FLT_FORM))
    else $error("type 2 local invalidate not faulted");
  chk_bcast_priv: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_take && op.bcast && op.priv != PRIV_HYP)
    |=> (op_done && op_fault == FLT_PRIV))
    else $error("broadcast below hypervisor not faulted");
  chk_guest_tlb_mgmt_disable_priv: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_take && !op.bcast && pctl_q[PCTL_GUEST_TLB_MGMT_DISABLE_BIT] && op.priv == PRIV_GUEST)
    |=> (op_fault == FLT_PRIV))
    else $error("guest local invalidate allowed while disabled");
  chk_local_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_take && !op.bcast) |=> (!bcast_valid)[*8])
    else $error("local invalidate was broadcast");
  chk_acks_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_done && search_q.bcast && fault_q == FLT_NONE)
    |-> $past(&(ack_seen_q | remote_ack)))
    else $error("broadcast completed before all remote acks");
  chk_scan_span: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(scan_on) |-> scan_on[*8])
    else $error("scan ended early");
  chk_mmu_arch_version_noall: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_take && op.bcast && mcfg_q[1:0] != 2'h0) |=> !search_q.all)
    else $error("invalidate-all left enabled for nonzero version");
  chk_strict_base: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_take && !op.bcast && op.priv == PRIV_HYP && op.ttype != TT_BAD &&
     pctl_q[PCTL_STRICT_BIT] && op.base_num != 5'h00)
    |=> (op_fault == FLT_ILL))
    else $error("nonzero base register not rejected");
endmodule

// File: verification/tlbiu_remote_model.sv
// Remote core model answering broadcast invalidates
`timescale 1ns/1ps
module tlbiu_remote_model
  import tlbiu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] delay,
  input wire logic bcast_valid,
  output logic bcast_ready,
  output logic [REMOTES-1:0] remote_ack
);
  int cnt;
  always @(posedge aclk) begin
    bcast_ready <= 1'b0;
    remote_ack <= '0;
    if (!aresetn) begin
      cnt <= 0;
    end else if (bcast_valid || cnt != 0) begin
      cnt <= (cnt == delay + 2 + REMOTES) ? 0 : cnt + 1;
      if (cnt == delay && bcast_valid) begin
        bcast_ready <= 1'b1;
      end
      for (int i = 0; i < REMOTES; i++) begin
        if (cnt == delay + 2 + i) begin
          remote_ack[i] <= 1'b1;
        end
      end
    end
  end
endmodule

// File: verification/tlbiu_top_test.sv
// Self-checking bench for the TLB invalidate unit
`timescale 1ns/1ps
module tlbiu_top_test
  import tlbiu_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata;
  logic awready, wready, bvalid, arready, rvalid, bc_seen;
  logic [1:0] bresp, rresp;
  logic op_valid = 0, op_ready, op_done, bcast_valid, bcast_ready;
  logic bcast_pending, snoop_valid = 0, snoop_ready, snoop_ack;
  logic fill_valid = 0;
  logic [1:0] fill_array = '0, rd_array = '0;
  logic [3:0] fill_index = '0, rd_index = '0, slow = '0;
  logic [REMOTES-1:0] remote_ack;
  tlbiu_op_type op = '0;
  tlbiu_fault_type op_fault;
  tlbiu_search_type bcast_out, bc_out, snoop_in = '0;
  tlbiu_entry_type fill_entry = '0, rd_entry;
  int errors = 0, num_checks = 0;
  time last_ack = 0;
  localparam logic [51:0] EPG = 52'h1_2345_6789_abcd;
  localparam logic [51:0] EPH = 52'h0_0000_0000_0042;
  localparam logic [63:0] EA = {EPG, 12'h000};
  localparam logic [1:0] PA [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
  localparam logic [3:0] PI [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};

  tlbiu_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .op_valid(op_valid),
    .op_ready(op_ready), .op(op), .op_done(op_done), .op_fault(op_fault),
    .bcast_valid(bcast_valid), .bcast_ready(bcast_ready),
    .bcast_out(bcast_out), .remote_ack(remote_ack),
    .bcast_pending(bcast_pending), .snoop_valid(snoop_valid),
    .snoop_ready(snoop_ready), .snoop_in(snoop_in), .snoop_ack(snoop_ack),
    .fill_valid(fill_valid), .fill_array(fill_array),
    .fill_index(fill_index), .fill_entry(fill_entry),
    .rd_array(rd_array), .rd_index(rd_index), .rd_entry(rd_entry));

  tlbiu_remote_model remote (.aclk(aclk), .aresetn(aresetn), .delay(slow),
    .bcast_valid(bcast_valid), .bcast_ready(bcast_ready),
    .remote_ack(remote_ack));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (bcast_valid) begin
      bc_seen = 1'b1;
      bc_out = bcast_out;
      cmp(bcast_pending, 1'h1);
    end
    if (|remote_ack) last_ack = $time;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready && !wd) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    cmp(bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    cmp(rdata, ed);
    cmp(rresp, er);
  endtask

  task automatic pop();
    tlbiu_entry_type e;
    for (int k = 0; k < 6; k++) begin
      e = '0;
      e.valid = 1'b1;
      e.lpid = (k == 3) ? 8'h06 : 8'h05;
      e.pid = (k == 1) ? 14'h0008 : 14'h0007;
      e.invalidate_protect = (k == 2);
      e.guest_state = (k == 4);
      e.effective_page_number = (k == 5) ? EPH : EPG;
      fill_valid <= 1'b1;
      fill_array <= PA[k];
      fill_index <= PI[k];
      fill_entry <= e;
      @(posedge aclk);
      fill_valid <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic chk6(input logic [5:0] ex);
    for (int k = 0; k < 6; k++) begin
      rd_array <= PA[k];
      rd_index <= PI[k];
      repeat (2) @(posedge aclk);
      cmp(rd_entry.valid, ex[k]);
    end
  endtask

  task automatic tc(input logic b, input logic [1:0] tt,
      input logic [4:0] bn, input logic [63:0] bv, input logic [63:0] iv,
      input tlbiu_priv_type pv, input tlbiu_fault_type ef,
      input logic [5:0] ex);
    time t0;
    pop();
    t0 = $time;
    bc_seen = 1'b0;
    op_valid <= 1'b1;
    op <= '{b, tt, bn, bv, iv, pv};
    do @(posedge aclk); while (!op_ready);
    op_valid <= 1'b0;
    do @(posedge aclk); while (!op_done);
    cmp(op_fault, ef);
    cmp(bc_seen, b && ef == FLT_NONE);
    if (bc_seen) cmp(last_ack > t0 && last_ack < $time, 1'h1);
    chk6(ex);
    $display("Test done: bcast %0d type %0d at %0t", b, tt, $time);
  endtask

  initial begin
    #100000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(REG_PCTL, PCTL_RST, RESP_OKAY);
    axr(REG_MCFG, ZERO_RST, RESP_OKAY);
    axr(REG_STAT, ZERO_RST, RESP_OKAY);
    axr(8'h40, ZERO_RST, RESP_SLVERR);
    axw(REG_STAT, 32'h0000_0001, RESP_SLVERR);
    axw(REG_CTXA, 32'h0000_0005, RESP_OKAY);
    axw(REG_CTXB, 32'h0000_0007, RESP_OKAY);
    axr(REG_CTXB, 32'h0000_0007, RESP_OKAY);
    tc(0, TT_LPID, '0, '0, '0, PRIV_GUEST, FLT_NONE, 6'h0c);
    tc(0, TT_PID, '0, '0, '0, PRIV_GUEST, FLT_NONE, 6'h0e);
    tc(0, TT_VA, '0, '1, EA, PRIV_GUEST, FLT_NONE, 6'h3e);
    tc(0, TT_VA, 5'h03, EA - 64'h1000, 64'h1000, PRIV_GUEST,
       FLT_NONE, 6'h3e);
    tc(0, TT_BAD, '0, '0, EA, PRIV_GUEST, FLT_FORM, 6'h3f);
    tc(0, TT_LPID, '0, '0, '0, PRIV_USER, FLT_PRIV, 6'h3f);
    axr(REG_STAT, 32'h0000_0020, RESP_OKAY);
    axw(REG_PCTL, 32'h0000_0005, RESP_OKAY);
    tc(0, TT_LPID, '0, '0, '0, PRIV_GUEST, FLT_PRIV, 6'h3f);
    tc(0, TT_LPID, '0, '0, '0, PRIV_HYP, FLT_NONE, 6'h0c);
    axw(REG_PCTL, 32'h0000_0006, RESP_OKAY);
    tc(0, TT_LPID, 5'h01, '0, '0, PRIV_GUEST, FLT_ILL, 6'h3f);
    axw(REG_PCTL, 32'h0000_0004, RESP_OKAY);
    tc(1, TT_LPID, '0, '0, EA, PRIV_GUEST, FLT_PRIV, 6'h3f);
    tc(1, TT_LPID, '0, '0, EA, PRIV_HYP, FLT_NONE, 6'h3e);
    cmp(bc_out.effective_page_number, EPG);
    slow <= 4'h5;
    tc(1, TT_LPID, '0, '0, EA | 64'h0c, PRIV_HYP, FLT_NONE, 6'h1f);
    cmp({bc_out.sel, bc_out.all}, 3'h3);
    slow <= 4'h0;
    tc(1, TT_LPID, '0, '0, EA | 64'h18, PRIV_HYP, FLT_NONE, 6'h3f);
    axw(REG_MCFG, 32'h0000_0001, RESP_OKAY);
    tc(1, TT_LPID, '0, '0, EA | 64'h0c, PRIV_HYP, FLT_NONE, 6'h3e);
    cmp(bc_out.all, 1'h0);
    axw(REG_MCFG, 32'h0000_0000, RESP_OKAY);
    axw(REG_PCTL, 32'h0000_0000, RESP_OKAY);
    tc(1, TT_LPID, '0, '0, EA | 64'h18, PRIV_HYP, FLT_NONE, 6'h2f);
    pop();
    snoop_in <= '{1, TT_LPID, 1, 1, 0, 2'h3, 8'h05, 14'h0007, 0, 1, EPG};
    snoop_valid <= 1'b1;
    do @(posedge aclk); while (!snoop_ready);
    snoop_valid <= 1'b0;
    do @(posedge aclk); while (!snoop_ack);
    chk6(6'h2f);
    $display("Test done: snoop at %0t", $time);
    complete_run();
  end
endmodule
